// ---- verilog/pos_pkg.sv ----
// Shared constants and types for the power operating-state controller
package pos_pkg;

   // Clock rate used to turn times into cycle counts
   localparam int unsigned CLK_FREQ_KHZ = 100000;

   // Startup configuration timeout, nominal of the 550..650 ms window
   localparam int unsigned INIT_TIMEOUT_MS = 600;
   localparam int unsigned INIT_CYC = INIT_TIMEOUT_MS * CLK_FREQ_KHZ;

   // Time spent in the fault state, normal case and after thermal shutdown
   localparam int unsigned FAULT_TIME_MS = 20;
   localparam int unsigned FAULT_CYC = FAULT_TIME_MS * CLK_FREQ_KHZ;
   localparam int unsigned FAULT_TSD_MS = 1000;
   localparam int unsigned FAULT_TSD_CYC = FAULT_TSD_MS * CLK_FREQ_KHZ;

   // Length of one host reset pulse
   localparam int unsigned RST_PULSE_US = 10;
   localparam int unsigned RST_PULSE_CYC = RST_PULSE_US * CLK_FREQ_KHZ / 1000;

   // Counter widths
   localparam int unsigned TMR_W = 27;
   localparam int unsigned RST_W = 10;

   // Hard faults that lead to the locked state
   localparam logic [1:0] HARD_FAULT_LIMIT = 2'h3;
   localparam logic [1:0] HARD_CNT_RST = 2'h0;

   // Bit positions of the event input vector
   localparam int unsigned EV_PRI_OV = 0;
   localparam int unsigned EV_PRI_UV = 1;
   localparam int unsigned EV_PRI_STG = 2;
   localparam int unsigned EV_SEC_OV = 3;
   localparam int unsigned EV_SEC_UV = 4;
   localparam int unsigned EV_SEC_STG = 5;
   localparam int unsigned EV_UP_OV = 6;
   localparam int unsigned EV_UP_UV = 7;
   localparam int unsigned EV_UP_STG = 8;
   localparam int unsigned EV_MON1_OV = 9;
   localparam int unsigned EV_MON1_UV = 10;
   localparam int unsigned EV_MON1_STG = 11;
   localparam int unsigned EV_MON2_OV = 12;
   localparam int unsigned EV_MON2_UV = 13;
   localparam int unsigned EV_MON2_STG = 14;
   localparam int unsigned EV_IO_OV = 15;
   localparam int unsigned EV_IO_UV = 16;
   localparam int unsigned EV_IO_STG = 17;
   localparam int unsigned EV_WD_INC = 18;
   localparam int unsigned EV_WD_OVF = 19;
   localparam int unsigned EV_BG_WARN = 20;
   localparam int unsigned EV_BG_FAULT = 21;
   localparam int unsigned EV_OTW_PRI = 22;
   localparam int unsigned EV_OTW_SEC = 23;
   localparam int unsigned EV_OTW_MON = 24;
   localparam int unsigned EV_OTF_PRI = 25;
   localparam int unsigned EV_OTF_SEC = 26;
   localparam int unsigned EV_OTF_MON = 27;
   localparam int unsigned EV_W = 28;

   // Operating states
   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_ACTIVE = 3'h1,
      ST_DISABLED = 3'h2,
      ST_FAULT = 3'h3,
      ST_LOCKED = 3'h4
   } pos_state_t;

endpackage

// ---- verilog/pos_evt_if.sv ----
// Carrier between the event classifier and the state controller
interface pos_evt_if;
   logic [pos_pkg::EV_W-1:0] ev; // Event pulses, one bit per source
   logic hard_fault; // Any event that forces the fault state
   logic thermal; // Hard fault caused by over-temperature
   logic reset_req; // Any event that asks for a host reset
   logic irq_req; // Any event that only raises an interrupt

   modport map_mp (input ev, output hard_fault, thermal, reset_req, irq_req);
   modport ctl_mp (output ev, input hard_fault, thermal, reset_req, irq_req);
endinterface

// ---- verilog/pos_evt_map.sv ----
// Event classifier: sorts each event into fault, reset or interrupt class
module pos_evt_map (
   pos_evt_if.map_mp evt // Event pulses in, classes out
);

   // Rail overvoltage and shorts except on the second monitor, band gap fault and over-temperature faults
   assign evt.hard_fault = evt.ev[pos_pkg::EV_PRI_OV] | evt.ev[pos_pkg::EV_PRI_STG]
      | evt.ev[pos_pkg::EV_SEC_OV] | evt.ev[pos_pkg::EV_SEC_STG]
      | evt.ev[pos_pkg::EV_UP_OV] | evt.ev[pos_pkg::EV_UP_STG]
      | evt.ev[pos_pkg::EV_MON1_OV] | evt.ev[pos_pkg::EV_MON1_STG]
      | evt.ev[pos_pkg::EV_IO_OV] | evt.ev[pos_pkg::EV_IO_STG]
      | evt.ev[pos_pkg::EV_BG_FAULT] | evt.thermal;

   // Thermal faults pick the long fault time
   assign evt.thermal = evt.ev[pos_pkg::EV_OTF_PRI] | evt.ev[pos_pkg::EV_OTF_SEC]
      | evt.ev[pos_pkg::EV_OTF_MON];

   // Undervoltage of supervised rails and watchdog overflow reset the host
   assign evt.reset_req = evt.ev[pos_pkg::EV_PRI_UV] | evt.ev[pos_pkg::EV_SEC_UV]
      | evt.ev[pos_pkg::EV_MON1_UV] | evt.ev[pos_pkg::EV_IO_UV]
      | evt.ev[pos_pkg::EV_WD_OVF];

   // Warnings, second-monitor events and the UP rail undervoltage only interrupt
   assign evt.irq_req = evt.ev[pos_pkg::EV_UP_UV] | evt.ev[pos_pkg::EV_MON2_OV]
      | evt.ev[pos_pkg::EV_MON2_UV] | evt.ev[pos_pkg::EV_MON2_STG]
      | evt.ev[pos_pkg::EV_WD_INC] | evt.ev[pos_pkg::EV_BG_WARN]
      | evt.ev[pos_pkg::EV_OTW_PRI] | evt.ev[pos_pkg::EV_OTW_SEC]
      | evt.ev[pos_pkg::EV_OTW_MON];

endmodule // pos_evt_map

// ---- verilog/pos_timer.sv ----
// One-shot down counter with start, stop and an expiry pulse
module pos_timer (
   input wire logic sys_clk, // System clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic ce, // Clock enable
   input wire logic start, // Load and run, pulse
   input wire logic stop, // Abort a running count, level
   input wire logic [pos_pkg::TMR_W-1:0] load, // Cycles to run
   output logic running, // Count in progress
   output logic expire // Last cycle of the count, pulse
);

   logic [pos_pkg::TMR_W-1:0] cnt_reg;
   logic run_reg;
   logic last;

   // Expiry is suppressed by a stop in the same cycle
   assign last = run_reg && (cnt_reg == {{(pos_pkg::TMR_W-1){1'b0}}, 1'b1});
   assign expire = last && !stop && !start && ce;
   assign running = run_reg;

   // Counter; start wins over stop so a restart is never lost
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
      end else if (ce) begin
         if (start) begin
            cnt_reg <= load;
            run_reg <= 1'b1;
         end else if (stop || last) begin
            run_reg <= 1'b0;
         end else if (run_reg) begin
            cnt_reg <= cnt_reg - {{(pos_pkg::TMR_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // pos_timer

// ---- verilog/pos_state_machine.sv ----
// Operating-state controller: ACTIVE, DISABLED, FAULT, LOCKED and supply-off
// What this block does
// - After power-on reset the controller leaves the off condition and enters ACTIVE.
// - ACTIVE to DISABLED needs the host request together with wake enable low.
// - ACTIVE to LOCKED needs the host request together with trigger config zero.
// - A hard-reset class fault seen in ACTIVE moves the controller to FAULT.
// - Hard faults are counted; the third leads from FAULT to LOCKED.
// - FAULT to LOCKED also needs edge-triggered wake enable or wake enable low.
// - A transition fires only when all its conditions hold together.
// - The startup timer expires after nominally 600 ms unless host activity stops it.
// - First startup timer expiry pulses host reset and keeps ACTIVE.
// - Second startup timer expiry counts as a hard fault and moves to FAULT.
// - Reset-class events pulse host reset and stay in or return to ACTIVE.
// - Rail events map to fault, host reset or interrupt per rail.
// - Watchdog, io rail and thermal events map to interrupt, reset or fault.
// - Band gap warning only raises an interrupt.
// - Band gap fault forces FAULT with all regulators off.
// - Internal supply fault shuts everything off; ACTIVE returns once it clears.
// - From DISABLED a valid enable event enters ACTIVE and resets host; registers clear on entering DISABLED.
// - LOCKED holds in low power until an enable event, then ACTIVE with host reset.
// - Host-requested exits pass through FAULT for the fault time first.
module pos_state_machine #(
   parameter int unsigned INIT_CYC = pos_pkg::INIT_CYC, // Startup timeout in cycles
   parameter int unsigned FAULT_CYC = pos_pkg::FAULT_CYC, // Fault time in cycles
   parameter int unsigned FAULT_TSD_CYC = pos_pkg::FAULT_TSD_CYC // Thermal fault time
) (
   input wire logic sys_clk, // System clock, 100 MHz
   input wire logic rst_b, // Power-on reset, asynchronous, active low
   input wire logic ce, // Clock enable, freezes all state when low
   input wire logic [pos_pkg::EV_W-1:0] event_in, // Monitor event levels, asynchronous
   input wire logic supply_fault_in, // Internal supply out of range, asynchronous
   input wire logic wake_enable_input, // Wake enable pin, asynchronous
   input wire logic enable_trigger_config, // 1 edge-triggered, 0 level wake enable
   input wire logic spi_req_disable, // Host request to go DISABLED, pulse
   input wire logic spi_req_lock, // Host request to go LOCKED, pulse
   input wire logic host_activity_ok, // Valid SPI and watchdog service seen, pulse
   output logic host_reset_output_b, // Host reset, low while asserted
   output logic regulators_on, // All rails enabled
   output logic low_power, // Reduced consumption while locked
   output logic clear_cfg_regs, // Clear configuration registers, pulse
   output logic clear_event_regs, // Clear event registers too, pulse
   output logic irq_out, // Interrupt to host, pulse
   output logic [2:0] state_out, // Current operating state code
   output logic [1:0] hard_fault_count // Hard faults seen so far
);

   // Input synchronisers: monitors and pins are not on this clock
   logic [pos_pkg::EV_W-1:0] ev_meta_reg;
   logic [pos_pkg::EV_W-1:0] ev_sync_reg;
   logic [pos_pkg::EV_W-1:0] ev_prev_reg;
   logic sf_meta_reg;
   logic sf_sync_reg;
   logic ena_meta_reg;
   logic ena_sync_reg;
   logic ena_prev_reg;

   // State and bookkeeping
   pos_pkg::pos_state_t state_reg;
   pos_pkg::pos_state_t state_next;
   logic [1:0] hard_cnt_reg;
   logic [1:0] hard_cnt_next;
   logic init_err_reg;
   logic init_err_next;
   logic via_req_reg;
   logic via_req_next;
   logic tgt_lock_reg;
   logic tgt_lock_next;
   logic thermal_reg;
   logic thermal_next;
   logic [pos_pkg::RST_W-1:0] rst_cnt_reg;
   logic [pos_pkg::RST_W-1:0] rst_cnt_next;
   logic rst_busy_prev_reg;

   // Registered outputs
   logic host_reset_b_reg;
   logic irq_reg;
   logic clr_cfg_reg;
   logic clr_evt_reg;

   // Decoded conditions
   logic [pos_pkg::EV_W-1:0] ev_rise;
   logic ena_edge;
   logic ena_event;
   logic lock_ok;
   logic in_active;
   logic in_fault;
   logic rst_busy;
   logic rst_release;
   logic req_dis_ok;
   logic req_lock_ok;
   logic init_expire;
   logic init_first;
   logic init_second;
   logic hard_any;
   logic soft_rst;
   logic enter_fault;
   logic enter_active;
   logic fault_start;
   logic fault_expire;
   logic init_running;
   logic [pos_pkg::TMR_W-1:0] fault_load;

   pos_evt_if evt ();

   // Two-flop synchronisers plus an edge-detect stage; the first stage is never read by logic
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ev_meta_reg <= '0;
         ev_sync_reg <= '0;
         ev_prev_reg <= '0;
      end else if (ce) begin
         ev_meta_reg <= event_in;
         ev_sync_reg <= ev_meta_reg;
         ev_prev_reg <= ev_sync_reg;
      end
   end

   // Supply fault and wake enable synchronisers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sf_meta_reg <= 1'b0;
         sf_sync_reg <= 1'b0;
         ena_meta_reg <= 1'b0;
         ena_sync_reg <= 1'b0;
         ena_prev_reg <= 1'b0;
      end else if (ce) begin
         sf_meta_reg <= supply_fault_in;
         sf_sync_reg <= sf_meta_reg;
         ena_meta_reg <= wake_enable_input;
         ena_sync_reg <= ena_meta_reg;
         ena_prev_reg <= ena_sync_reg;
      end
   end

   // Monitor outputs are levels; act once per onset, not every cycle
   genvar gi;
   generate
      for (gi = 0; gi < pos_pkg::EV_W; gi++) begin : g_rise
         assign ev_rise[gi] = ev_sync_reg[gi] & ~ev_prev_reg[gi];
      end
   endgenerate

   assign evt.ev = ev_rise;

   // Event classifier
   pos_evt_map u_map (
      .evt(evt.map_mp)
   );

   // Wake enable: edge mode wants a rising edge, level mode a high level
   assign ena_edge = ena_sync_reg & ~ena_prev_reg;
   assign ena_event = enable_trigger_config ? ena_edge : ena_sync_reg;
   assign lock_ok = enable_trigger_config | ~ena_sync_reg;

   assign in_active = (state_reg == pos_pkg::ST_ACTIVE);
   assign in_fault = (state_reg == pos_pkg::ST_FAULT);

   // Host requests need every condition at once, else they are dropped
   assign req_dis_ok = spi_req_disable & ~ena_sync_reg;
   assign req_lock_ok = spi_req_lock & ~enable_trigger_config;

   // Host reset pulse tracking; the startup timer starts at its release
   assign rst_busy = (rst_cnt_reg != '0);
   assign rst_release = rst_busy_prev_reg & ~rst_busy & in_active;

   // Startup configuration timer; valid host activity stops it
   pos_timer u_init_tmr (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .ce(ce),
      .start(rst_release),
      .stop(host_activity_ok | ~in_active | rst_busy),
      .load(pos_pkg::TMR_W'(INIT_CYC)),
      .running(init_running),
      .expire(init_expire)
   );

   // First expiry is a soft reset, the second escalates to a hard fault
   assign init_first = init_expire & ~init_err_reg;
   assign init_second = init_expire & init_err_reg;

   // Fault and reset classes only matter while the rails are up
   assign hard_any = in_active & (evt.hard_fault | init_second);
   assign soft_rst = in_active & (evt.reset_req | init_first);

   assign enter_fault = (state_next == pos_pkg::ST_FAULT) & ~in_fault;
   assign enter_active = (state_next == pos_pkg::ST_ACTIVE) & ~in_active;

   // Fault timer; thermal shutdown holds the rails off much longer
   assign fault_start = enter_fault;
   assign fault_load = thermal_next ? pos_pkg::TMR_W'(FAULT_TSD_CYC)
      : pos_pkg::TMR_W'(FAULT_CYC);

   pos_timer u_fault_tmr (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .ce(ce),
      .start(fault_start),
      .stop(~in_fault),
      .load(fault_load),
      .running(),
      .expire(fault_expire)
   );

   // Transition table; every branch resolves within one cycle
   always_comb begin
      state_next = state_reg;
      hard_cnt_next = hard_cnt_reg;
      via_req_next = via_req_reg;
      tgt_lock_next = tgt_lock_reg;
      thermal_next = thermal_reg;
      if (sf_sync_reg) begin
         // Internal supply loss overrides everything
         state_next = pos_pkg::ST_OFF;
      end else begin
         case (state_reg)
            pos_pkg::ST_OFF: begin
               state_next = pos_pkg::ST_ACTIVE;
            end
            pos_pkg::ST_ACTIVE: begin
               if (hard_any) begin
                  state_next = pos_pkg::ST_FAULT;
                  via_req_next = 1'b0;
                  thermal_next = evt.thermal;
                  if (hard_cnt_reg != pos_pkg::HARD_FAULT_LIMIT) begin
                     hard_cnt_next = hard_cnt_reg + 2'h1;
                  end
               end else if (req_dis_ok) begin
                  state_next = pos_pkg::ST_FAULT;
                  via_req_next = 1'b1;
                  tgt_lock_next = 1'b0;
                  thermal_next = 1'b0;
               end else if (req_lock_ok) begin
                  state_next = pos_pkg::ST_FAULT;
                  via_req_next = 1'b1;
                  tgt_lock_next = 1'b1;
                  thermal_next = 1'b0;
               end
            end
            pos_pkg::ST_FAULT: begin
               if (via_req_reg) begin
                  if (fault_expire) begin
                     // Outputs discharged, now take the requested state
                     state_next = tgt_lock_reg ? pos_pkg::ST_LOCKED
                        : pos_pkg::ST_DISABLED;
                  end
               end else if (hard_cnt_reg == pos_pkg::HARD_FAULT_LIMIT) begin
                  // Third hard fault never returns to ACTIVE
                  if (lock_ok) begin
                     state_next = pos_pkg::ST_LOCKED;
                  end
               end else if (fault_expire) begin
                  state_next = pos_pkg::ST_ACTIVE;
               end
            end
            pos_pkg::ST_DISABLED: begin
               if (ena_event) begin
                  state_next = pos_pkg::ST_ACTIVE;
               end
            end
            pos_pkg::ST_LOCKED: begin
               if (ena_event) begin
                  state_next = pos_pkg::ST_ACTIVE;
               end
            end
            default: begin
               state_next = pos_pkg::ST_OFF;
            end
         endcase
         // Counter restarts once the controller has been locked or disabled
         if (state_next == pos_pkg::ST_LOCKED || state_next == pos_pkg::ST_DISABLED) begin
            hard_cnt_next = pos_pkg::HARD_CNT_RST;
         end
      end
   end

   // Startup error memory: cleared by successful host start or a hard reset
   always_comb begin
      init_err_next = init_err_reg;
      if (init_first) begin
         init_err_next = 1'b1;
      end else if (enter_fault || (host_activity_ok && init_running)) begin
         init_err_next = 1'b0;
      end
   end

   // Host reset pulse: (re)loaded on entering ACTIVE or on a soft reset
   always_comb begin
      rst_cnt_next = rst_cnt_reg;
      if (enter_active || (soft_rst && state_next == pos_pkg::ST_ACTIVE)) begin
         rst_cnt_next = pos_pkg::RST_W'(pos_pkg::RST_PULSE_CYC);
      end else if (rst_busy) begin
         rst_cnt_next = rst_cnt_reg - {{(pos_pkg::RST_W-1){1'b0}}, 1'b1};
      end
   end

   // State registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= pos_pkg::ST_OFF;
         hard_cnt_reg <= pos_pkg::HARD_CNT_RST;
         via_req_reg <= 1'b0;
         tgt_lock_reg <= 1'b0;
         thermal_reg <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         hard_cnt_reg <= hard_cnt_next;
         via_req_reg <= via_req_next;
         tgt_lock_reg <= tgt_lock_next;
         thermal_reg <= thermal_next;
      end
   end

   // Startup error flag and reset pulse counter
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         init_err_reg <= 1'b0;
         rst_cnt_reg <= '0;
         rst_busy_prev_reg <= 1'b0;
      end else if (ce) begin
         init_err_reg <= init_err_next;
         rst_cnt_reg <= rst_cnt_next;
         rst_busy_prev_reg <= rst_busy;
      end
   end

   // Output flops; reset is held low in every state but a settled ACTIVE
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         host_reset_b_reg <= 1'b0;
         irq_reg <= 1'b0;
         clr_cfg_reg <= 1'b0;
         clr_evt_reg <= 1'b0;
      end else if (ce) begin
         host_reset_b_reg <= (state_next == pos_pkg::ST_ACTIVE) && (rst_cnt_next == '0);
         irq_reg <= in_active & evt.irq_req;
         clr_cfg_reg <= (state_next != state_reg) && (state_next != pos_pkg::ST_ACTIVE);
         clr_evt_reg <= (state_next == pos_pkg::ST_DISABLED)
            && (state_reg != state_next);
      end
   end

   assign host_reset_output_b = host_reset_b_reg;
   assign irq_out = irq_reg;
   assign clear_cfg_regs = clr_cfg_reg;
   assign clear_event_regs = clr_evt_reg;

   // Regulators run only in ACTIVE; fault and locked switch them off
   assign regulators_on = in_active;
   assign low_power = (state_reg == pos_pkg::ST_LOCKED);
   assign state_out = state_reg;
   assign hard_fault_count = hard_cnt_reg;

endmodule // pos_state_machine

// ---- verification/pos_state_machine_properties.sv ----
// Port-level checks of the operating-state controller
module pos_sm_checker (
   input wire logic sys_clk, // Clock
   input wire logic rst_b, // Reset
   input wire logic ce, // Enable
   input wire logic [pos_pkg::EV_W-1:0] event_in, // Events
   input wire logic supply_fault_in, // Supply
   input wire logic wake_enable_input, // Wake pin
   input wire logic enable_trigger_config, // Mode
   input wire logic spi_req_disable, // Request
   input wire logic spi_req_lock, // Request
   input wire logic host_reset_output_b, // Host reset
   input wire logic regulators_on, // Rails
   input wire logic low_power, // Locked
   input wire logic irq_out, // Interrupt
   input wire logic [2:0] state_out, // State
   input wire logic [1:0] hard_fault_count // Count
);
   // Nothing pending in the synchronisers, so no event can race a request
   logic calm;
   assign calm = ce && event_in == '0 && !supply_fault_in;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   outputs_state_a: assert property (
      regulators_on == (state_out == 3'h1) && low_power == (state_out == 3'h4))
      else $error("rail or low power output wrong");
   req_dis_a: assert property (
      (calm && !wake_enable_input)[*4] ##0 (state_out == 3'h1 && spi_req_disable)
      |=> state_out == 3'h3) else $error("disable request not taken");
   req_lock_a: assert property (
      calm[*4] ##0 (state_out == 3'h1 && spi_req_lock && !enable_trigger_config)
      |=> state_out == 3'h3) else $error("lock request not taken");
   refused_req_a: assert property (
      calm[*4] ##0 (state_out == 3'h1 && spi_req_lock && enable_trigger_config
      && !spi_req_disable) |=> state_out == 3'h1
      || hard_fault_count != $past(hard_fault_count)) else $error("partial match acted");
   hard_evt_a: assert property (
      state_out == 3'h1 && ce && $rose(event_in[pos_pkg::EV_PRI_OV])
      |-> ##[1:5] state_out inside {3'h0, 3'h3}) else $error("overvoltage missed");
   rst_evt_a: assert property (
      calm[*3] ##1 (state_out == 3'h1 && host_reset_output_b && event_in == 28'h0080000)
      |-> ##[1:5] (!host_reset_output_b && state_out == 3'h1)) else $error("no host reset");
   irq_only_a: assert property (
      calm[*3] ##1 (state_out == 3'h1 && event_in == 28'h0100000)
      |-> ##[1:5] (irq_out && state_out == 3'h1)) else $error("no interrupt");
   third_lock_a: assert property (
      state_out == 3'h3 && hard_fault_count == 2'h3 && enable_trigger_config && calm
      |-> ##[0:3] state_out inside {3'h0, 3'h4}) else $error("third fault not locked");
   cover property (state_out == 3'h2);
   cover property (state_out == 3'h4);
   cover property (irq_out);
endmodule // pos_sm_checker

bind pos_state_machine pos_sm_checker chk (.*);

// ---- verification/pos_host_model.sv ----
// Host controller model: state requests and periodic service
module pos_host_model (
   input wire logic sys_clk, // Clock
   input wire logic host_reset_output_b, // Reset from device
   input wire logic serve, // Service enable, low lets the startup timer run out
   output logic spi_req_disable, // Request pulse
   output logic spi_req_lock, // Request pulse
   output logic host_activity_ok // Service pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0] svc_reg;
   initial begin
      spi_req_disable = 1'b0;
      spi_req_lock = 1'b0;
      host_activity_ok = 1'b0;
      svc_reg = 6'h00;
   end
   // Service only while out of reset, as a real host would
   always @(posedge sys_clk) begin
      #1;
      svc_reg <= svc_reg + 6'h01;
      host_activity_ok <= serve && host_reset_output_b && svc_reg == 6'h00;
   end
   // One-cycle request, launched just after an edge
   task automatic send(input logic to_disable);
      @(posedge sys_clk) #1;
      spi_req_disable = to_disable;
      spi_req_lock = !to_disable;
      @(posedge sys_clk) #1;
      spi_req_disable = 1'b0;
      spi_req_lock = 1'b0;
   endtask
endmodule // pos_host_model

// ---- verification/pos_state_machine_tb.sv ----
// Self-checking bench for the operating-state controller
module pos_state_machine_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, rst_b, serve, wake, cfg, sup, dis, lck, ok, rb, rg, lp, irq, ce, ccr, cer;
   logic [pos_pkg::EV_W-1:0] ev;
   logic [2:0] st, seen;
   logic [1:0] hfc;
   int fail_count, total_checks, cyc, n;
   // Expected {fault, host reset, interrupt} for each event bit
   logic [2:0] kind_tab [pos_pkg::EV_W] = '{6, 2, 6, 6, 2, 6, 6, 1, 6, 6, 2, 6, 1, 1, 1,
      6, 2, 6, 1, 2, 1, 6, 1, 1, 1, 6, 6, 6};
   pos_state_machine #(.INIT_CYC(200), .FAULT_CYC(50), .FAULT_TSD_CYC(100)) dut (
      .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .event_in(ev), .supply_fault_in(sup),
      .wake_enable_input(wake), .enable_trigger_config(cfg), .spi_req_disable(dis),
      .spi_req_lock(lck), .host_activity_ok(ok), .host_reset_output_b(rb),
      .regulators_on(rg), .low_power(lp), .clear_cfg_regs(ccr), .clear_event_regs(cer),
      .irq_out(irq), .state_out(st), .hard_fault_count(hfc));
   pos_host_model host (.sys_clk(sys_clk), .host_reset_output_b(rb), .serve(serve),
      .spi_req_disable(dis), .spi_req_lock(lck), .host_activity_ok(ok));
   task automatic complete_run();
      if (fail_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic wait_st(input logic [2:0] s, input int k);
      for (int i = 0; i < k && st !== s; i++) tick(1);
      chk(st, s);
   endtask
   // Back to ACTIVE with reset released; a wake edge leaves DISABLED or LOCKED
   task automatic settle();
      for (int i = 0; i < 3000 && !(st === 3'h1 && rb === 1'b1); i++) begin
         if (st === 3'h4 || st === 3'h2) begin
            wake = 1'b0;
            tick(4);
            wake = 1'b1;
         end
         tick(1);
      end
      tick(4);
   endtask
   // Hold an event 8 cycles and note what it caused
   task automatic fire(input int b);
      ev[b] = 1'b1;
      seen = 3'h0;
      repeat (8) begin
         tick(1);
         seen = seen | {st === 3'h3, rb === 1'b0, irq === 1'b1};
      end
      ev[b] = 1'b0;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Hang guard, well above the expected run length
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 100000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      {rst_b, sup, ev} = '0;
      {ce, serve, wake, cfg} = 4'hF;
      tick(8);
      chk(st, 3'h0);
      rst_b = 1'b1;
      wait_st(3'h1, 5);
      settle();
      for (int b = 0; b < pos_pkg::EV_W; b++) begin
         fire(b);
         chk(seen, kind_tab[b]);
         settle();
      end
      // Third fault in level mode with wake high must wait in FAULT
      cfg = 1'b0;
      while (hfc !== 2'h2) begin
         fire(0);
         settle();
      end
      fire(2);
      tick(120);
      chk({st, hfc}, {3'h3, 2'h3});
      wake = 1'b0;
      wait_st(3'h4, 10);
      chk(hfc, 2'h0);
      settle();
      // Disable: FAULT for the fault time, then DISABLED, wake returns
      wake = 1'b0;
      tick(4);
      host.send(1'b1);
      chk(st, 3'h3);
      chk(ccr, 1'b1);
      tick(40);
      chk(st, 3'h3);
      wait_st(3'h2, 30);
      chk(cer, 1'b1);
      wake = 1'b1;
      wait_st(3'h1, 10);
      chk(rb, 1'b0);
      settle();
      // Partial conditions: no change
      host.send(1'b1);
      tick(5);
      chk(st, 3'h1);
      cfg = 1'b1;
      host.send(1'b0);
      tick(5);
      chk(st, 3'h1);
      // Lock request in level mode, left by wake high
      cfg = 1'b0;
      wake = 1'b0;
      tick(4);
      host.send(1'b0);
      chk(st, 3'h3);
      wait_st(3'h4, 80);
      chk(lp, 1'b1);
      wake = 1'b1;
      wait_st(3'h1, 10);
      chk(rb, 1'b0);
      settle();
      // Startup timer unserviced: soft reset first, then FAULT
      serve = 1'b0;
      fire(pos_pkg::EV_WD_OVF);
      for (n = 0; n < 1200 && rb !== 1'b1; n++) tick(1);
      for (n = 0; n < 300 && rb !== 1'b0; n++) tick(1);
      chk(n >= 195 && n <= 210, 1'b1);
      chk(st, 3'h1);
      for (n = 0; n < 1200 && rb !== 1'b1; n++) tick(1);
      wait_st(3'h3, 260);
      chk(hfc, 2'h1);
      serve = 1'b1;
      settle();
      // Internal supply out of range
      sup = 1'b1;
      wait_st(3'h0, 6);
      chk(rg, 1'b0);
      sup = 1'b0;
      wait_st(3'h1, 6);
      chk(rb, 1'b0);
      // Clock enable low must freeze the state even against a supply fault
      {ce, sup} = 2'h1;
      tick(6);
      chk(st, 3'h1);
      {ce, sup} = 2'h2;
      // Second reset mid-run
      rst_b = 1'b0;
      tick(2);
      chk({st, rb}, 4'h0);
      rst_b = 1'b1;
      wait_st(3'h1, 5);
      complete_run();
   end
endmodule // pos_state_machine_tb
